// ---- pkg/local_bus_grant_pkg.sv ----
package local_bus_grant_pkg;

    // ****************************************************************
    // pin bundle and synchroniser
    // ****************************************************************
    typedef struct packed
    {
        logic grant_n;
        logic local_req_n;
        logic busy_n;
    } pin_in_t;

    // all three pins reset high in the synchroniser; the busy line idles at its strap resistor level
    localparam pin_in_t PIN_IDLE = '{grant_n: 1'b1, local_req_n: 1'b1, busy_n: 1'b1};
    localparam int      PIN_WIDTH = $bits(pin_in_t);

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int         CLK_PERIOD_NS = 100;
    // edges after reset release before the synchronised strap is real
    localparam logic [1:0] STRAP_SETTLE  = 2'h2;
    localparam logic [1:0] SETTLE_STEP   = 2'h1;
    localparam logic [1:0] SETTLE_RESET  = 2'h0;

    // ****************************************************************
    // arbiter states
    // ****************************************************************
    typedef enum logic [4:0]
    {
        ST_STRAP = 5'h01,
        ST_IDLE  = 5'h02,
        ST_WAIT  = 5'h04,
        ST_SELF  = 5'h08,
        ST_LOCAL = 5'h10
    } arb_state_t;

endpackage

// ---- src/pin_sync.sv ----
module pin_sync
    import local_bus_grant_pkg::*;
(
    input  wire logic    clk,
    input  wire logic    arst_n,
    input  wire pin_in_t d,
    output pin_in_t      q
);

    pin_in_t stage1;

    // stage1 feeds only q; nothing else may look at it
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stage1 <= PIN_IDLE;
            q      <= PIN_IDLE;
        end
        else
        begin
            stage1 <= d;
            q      <= stage1;
        end
    end

endmodule

// ---- src/local_bus_grant_handshake.sv ----
// Functional notes
// - all local-side logic runs on the clock supplied by the local processor
// - the bus owner drives the ownership line active while it holds the bus
// - in bypass mode the ownership line is never relied upon
// - ownership line sampled at power-up: high enables arbiter, low bypasses
// - on grant, acknowledge own request or, with the arbiter enabled, grant the local requester
// - processor bus request asserted whenever local request is asserted
module local_bus_grant_handshake
    import local_bus_grant_pkg::*;
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic cpu_grant_in_n,
    input  wire logic local_request_in_n,
    input  wire logic bus_busy_n_in,
    output logic      bus_busy_n_out,
    output logic      bus_busy_n_oe,
    input  wire logic self_request,
    output logic      self_grant,
    output logic      cpu_request_out_n,
    output logic      local_grant_out_n,
    output logic      arbiter_enabled,
    output logic      mode_ready
);

    // ****************************************************************
    // pin synchronisation
    // ****************************************************************
    pin_in_t    pin_raw;
    pin_in_t    pin;
    logic       cpu_grant;
    logic       local_req;
    logic [1:0] settle;
    arb_state_t state;
    arb_state_t next_state;
    logic       serve_self;
    logic       next_serve_self;

    assign pin_raw = '{grant_n: cpu_grant_in_n, local_req_n: local_request_in_n,
                       busy_n: bus_busy_n_in};

    // clk is the processor-supplied local clock
    pin_sync u_pin_sync
    (
        .clk    (clk),
        .arst_n (arst_n),
        .d      (pin_raw),
        .q      (pin)
    );

    assign cpu_grant = !pin.grant_n;
    assign local_req = !pin.local_req_n;

    // bus counts as free when the line is high, or always in bypass
    function automatic logic owner_free(input logic arb_on, input logic busy_n);
        return !arb_on || busy_n;
    endfunction

    // ****************************************************************
    // power-up mode strap
    // ****************************************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            settle <= SETTLE_RESET;
        else if (settle != STRAP_SETTLE)
            settle <= settle + SETTLE_STEP;
    end

    // strap taken once, after the synchroniser holds the real pin level
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            arbiter_enabled <= 1'b0;
            mode_ready      <= 1'b0;
        end
        else if (!mode_ready && settle == STRAP_SETTLE)
        begin
            arbiter_enabled <= pin.busy_n;
            mode_ready      <= 1'b1;
        end
    end

    // ****************************************************************
    // arbitration state machine
    // ****************************************************************
    always_comb
    begin
        next_state      = state;
        next_serve_self = serve_self;
        case (state)
            ST_STRAP:
            begin
                if (mode_ready)
                    next_state = ST_IDLE;
            end
            ST_IDLE:
            begin
                // own request first: it is the shorter tenure in practice
                if (self_request)
                begin
                    next_state      = ST_WAIT;
                    next_serve_self = 1'b1;
                end
                else if (local_req)
                begin
                    next_state      = ST_WAIT;
                    next_serve_self = 1'b0;
                end
            end
            ST_WAIT:
            begin
                if (serve_self && !self_request)
                    next_state = ST_IDLE;
                else if (!serve_self && !local_req)
                    next_state = ST_IDLE;
                else if (cpu_grant && owner_free(arbiter_enabled, pin.busy_n))
                    next_state = serve_self ? ST_SELF : ST_LOCAL;
            end
            ST_SELF:
            begin
                if (!self_request)
                    next_state = ST_IDLE;
            end
            ST_LOCAL:
            begin
                // wait for withdrawal and, with the arbiter enabled, release of the busy line
                if (!local_req && owner_free(arbiter_enabled, pin.busy_n))
                    next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state      <= ST_STRAP;
            serve_self <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            serve_self <= next_serve_self;
        end
    end

    // ****************************************************************
    // registered outputs
    // ****************************************************************
    // request also follows the pin during the strap window
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cpu_request_out_n <= 1'b1;
        else
            cpu_request_out_n <= !(local_req || next_state == ST_WAIT ||
                                   next_state == ST_SELF || next_state == ST_LOCAL);
    end

    // in bypass the processor grant reaches the requester directly
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            self_grant        <= 1'b0;
            local_grant_out_n <= 1'b1;
        end
        else
        begin
            self_grant        <= next_state == ST_SELF;
            local_grant_out_n <= !(next_state == ST_LOCAL && arbiter_enabled);
        end
    end

    // we own the bus only in ST_SELF; in ST_LOCAL the local requester drives it
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus_busy_n_oe  <= 1'b0;
            bus_busy_n_out <= 1'b1;
        end
        else
        begin
            bus_busy_n_oe  <= next_state == ST_SELF;
            bus_busy_n_out <= next_state != ST_SELF;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_req_follows_local;
        local_req |=> !cpu_request_out_n;
    endproperty
    a_req_follows_local: assert property (p_req_follows_local)
        else $error("cpu request not asserted after local request");

    property p_owner_drives_busy;
        self_grant |-> (bus_busy_n_oe && !bus_busy_n_out);
    endproperty
    a_owner_drives_busy: assert property (p_owner_drives_busy)
        else $error("busy line not driven while device owns bus");

    property p_strap_sample;
        $rose(mode_ready) |-> arbiter_enabled == $past(pin.busy_n);
    endproperty
    a_strap_sample: assert property (p_strap_sample)
        else $error("arbiter mode differs from strapped level");

    property p_strap_hold;
        mode_ready |=> ($stable(arbiter_enabled) && mode_ready);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("arbiter mode changed after power-up");

    property p_bypass_ignores_busy;
        (!arbiter_enabled && state == ST_WAIT && serve_self && self_request && cpu_grant)
            |=> self_grant;
    endproperty
    a_bypass_ignores_busy: assert property (p_bypass_ignores_busy)
        else $error("bypass grant held off by busy line");

    property p_grant_self;
        (state == ST_WAIT && serve_self && self_request && cpu_grant && pin.busy_n)
            |=> (self_grant && local_grant_out_n);
    endproperty
    a_grant_self: assert property (p_grant_self)
        else $error("own request not acknowledged on grant");

    property p_grant_local;
        (state == ST_WAIT && !serve_self && local_req && cpu_grant && pin.busy_n &&
         arbiter_enabled) |=> (!local_grant_out_n && !self_grant);
    endproperty
    a_grant_local: assert property (p_grant_local)
        else $error("local requester not granted");

    property p_single_grant;
        !(self_grant && !local_grant_out_n) && !(!arbiter_enabled && !local_grant_out_n);
    endproperty
    a_single_grant: assert property (p_single_grant)
        else $error("conflicting grants");

    property p_release;
        (state == ST_LOCAL && !local_req && pin.busy_n && !self_request)
            |=> (cpu_request_out_n && local_grant_out_n) ##1 local_grant_out_n;
    endproperty
    a_release: assert property (p_release)
        else $error("request not withdrawn after local release");

    c_self_tenure:  cover property (state == ST_WAIT ##1 self_grant [*3] ##1 !self_grant);
    c_local_tenure: cover property (!local_grant_out_n [*2] ##[1:20] local_grant_out_n);
    c_bypass_mode:  cover property ($rose(mode_ready) && !arbiter_enabled);
    c_abandoned:    cover property (state == ST_WAIT ##1 state == ST_IDLE);

endmodule

// ---- sim/local_bus_partner.sv ----
module local_bus_partner
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       cpu_request_out_n,
    input  wire logic       local_grant_out_n,
    input  wire logic       want,
    input  wire logic       bypass,
    input  wire logic [3:0] grant_delay,
    output logic            cpu_grant_in_n,
    output logic            local_request_in_n,
    output logic            busy_drive
);
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************
    // processor side and local requester
    // ************************************************
    logic [3:0] cnt;

    assign local_request_in_n = ~want;

    // grant withdrawn as soon as the request drops, so no stale grant lingers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt            <= 4'h0;
            cpu_grant_in_n <= 1'b1;
        end
        else if (cpu_request_out_n)
        begin
            cnt            <= 4'h0;
            cpu_grant_in_n <= 1'b1;
        end
        else if (cnt >= grant_delay)
            cpu_grant_in_n <= 1'b0;
        else
            cnt <= cnt + 4'h1;
    end

    // in bypass the processor grant goes straight to the requester
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            busy_drive <= 1'b0;
        else if (!want)
            busy_drive <= 1'b0;
        else if (bypass ? !cpu_grant_in_n : !local_grant_out_n)
            busy_drive <= 1'b1;
    end
endmodule

// ---- sim/local_bus_grant_handshake_tb.sv ----
module local_bus_grant_handshake_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************
    // wiring
    // ************************************************
    logic       clk, arst_n, self_request, want, bypass, pull, noise;
    logic [3:0] grant_delay;
    logic       cpu_grant_in_n, local_request_in_n, busy_drive, busy_wire;
    logic       bus_busy_n_out, bus_busy_n_oe, self_grant, cpu_request_out_n;
    logic       local_grant_out_n, arbiter_enabled, mode_ready;
    int         failures, tests_run;

    // undriven ownership line falls to the strap resistor level
    assign busy_wire = bus_busy_n_oe ? bus_busy_n_out : (busy_drive ? 1'b0 : pull);

    local_bus_grant_handshake u_local_bus_grant_handshake (.clk(clk), .arst_n(arst_n),
        .cpu_grant_in_n(cpu_grant_in_n), .local_request_in_n(local_request_in_n),
        .bus_busy_n_in(busy_wire), .bus_busy_n_out(bus_busy_n_out),
        .bus_busy_n_oe(bus_busy_n_oe), .self_request(self_request),
        .self_grant(self_grant), .cpu_request_out_n(cpu_request_out_n),
        .local_grant_out_n(local_grant_out_n), .arbiter_enabled(arbiter_enabled),
        .mode_ready(mode_ready));

    local_bus_partner u_local_bus_partner (.clk(clk), .arst_n(arst_n),
        .cpu_request_out_n(cpu_request_out_n), .local_grant_out_n(local_grant_out_n),
        .want(want), .bypass(bypass), .grant_delay(grant_delay),
        .cpu_grant_in_n(cpu_grant_in_n), .local_request_in_n(local_request_in_n),
        .busy_drive(busy_drive));

    initial
    begin
        clk = 1'b0;
        forever #(local_bus_grant_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
    end

    // bypass may leave the line at no defined level: make it wander
    always @(posedge clk)
        if (noise && mode_ready)
            pull <= ~pull;

    // ************************************************
    // helpers
    // ************************************************
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check_bit(input string name, input logic exp, input logic seen);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %b seen %b", name, exp, seen);
        end
    endtask

    function automatic logic pick(input int which);
        case (which)
            0:       return self_grant;
            1:       return cpu_request_out_n;
            default: return local_grant_out_n;
        endcase
    endfunction

    // bounded wait; the compare that follows reports a miss
    task automatic wait_for(input int which, input logic lvl, input int max);
        for (int n = 0; n < max && pick(which) !== lvl; n++)
            step(1);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ************************************************
    // scenarios
    // ************************************************
    task automatic do_reset(input logic lvl);
        @(posedge clk)
        begin
            arst_n <= 1'b0;
            pull   <= lvl;
            noise  <= 1'b0;
            bypass <= ~lvl;
        end
        step(8);
        check_bit("oe_reset", 1'b0, bus_busy_n_oe);
        check_bit("req_reset", 1'b1, cpu_request_out_n);
        check_bit("lgnt_reset", 1'b1, local_grant_out_n);
        @(posedge clk) arst_n <= 1'b1;
        step(2);
        check_bit("ready_early", 1'b0, mode_ready);
        step(1);
        check_bit("ready", 1'b1, mode_ready);
        check_bit("mode", lvl, arbiter_enabled);
        step(1);
        noise <= ~lvl;
        $display("test reset %b done", lvl);
    endtask

    task automatic test_self(input logic [3:0] dly);
        grant_delay = dly;
        // let the last tenure's grant drain out of the synchroniser
        step(4);
        @(posedge clk) self_request <= 1'b1;
        step(1);
        check_bit("self_req", 1'b0, cpu_request_out_n);
        wait_for(0, 1'b1, 30);
        check_bit("self_grant", 1'b1, self_grant);
        check_bit("self_lgnt", 1'b1, local_grant_out_n);
        check_bit("self_oe", 1'b1, bus_busy_n_oe);
        check_bit("self_busy", 1'b0, busy_wire);
        step(3);
        check_bit("self_hold", 1'b1, self_grant);
        @(posedge clk) self_request <= 1'b0;
        step(1);
        check_bit("self_drop", 1'b0, self_grant);
        check_bit("self_oe_off", 1'b0, bus_busy_n_oe);
        check_bit("self_req_off", 1'b1, cpu_request_out_n);
        $display("test self %0d done", dly);
    endtask

    // own request withdrawn before the slow grant arrives
    task automatic test_abandon;
        grant_delay = 4'hf;
        step(4);
        @(posedge clk) self_request <= 1'b1;
        step(3);
        check_bit("abn_req", 1'b0, cpu_request_out_n);
        @(posedge clk) self_request <= 1'b0;
        step(1);
        check_bit("abn_req_off", 1'b1, cpu_request_out_n);
        check_bit("abn_grant", 1'b0, self_grant);
        step(20);
        check_bit("abn_late", 1'b0, self_grant);
        check_bit("abn_oe", 1'b0, bus_busy_n_oe);
        $display("test abandon done");
    endtask

    task automatic test_local(input logic arb);
        @(posedge clk) want <= 1'b1;
        wait_for(1, 1'b0, 4);
        check_bit("loc_req", 1'b0, cpu_request_out_n);
        if (arb)
            wait_for(2, 1'b0, 30);
        else
            step(20);
        check_bit("loc_grant", ~arb, local_grant_out_n);
        check_bit("loc_self", 1'b0, self_grant);
        step(2);
        check_bit("loc_busy", 1'b0, busy_wire);
        check_bit("loc_oe", 1'b0, bus_busy_n_oe);
        check_bit("loc_req_hold", 1'b0, cpu_request_out_n);
        @(posedge clk) want <= 1'b0;
        wait_for(1, 1'b1, 5);
        check_bit("loc_req_off", 1'b1, cpu_request_out_n);
        check_bit("loc_grant_off", 1'b1, local_grant_out_n);
        $display("test local %b done", arb);
    endtask

    // ************************************************
    // sequence and watchdog
    // ************************************************
    initial
    begin
        arst_n       = 1'b0;
        self_request = 1'b0;
        want         = 1'b0;
        bypass       = 1'b0;
        pull         = 1'b1;
        noise        = 1'b0;
        grant_delay  = 4'h0;
        failures     = 0;
        tests_run    = 0;
        do_reset(1'b1);
        test_self(4'h0);
        test_local(1'b1);
        test_self(4'h6);
        test_abandon();
        do_reset(1'b0);
        test_self(4'h2);
        test_local(1'b0);
        tally_and_finish();
    end

    initial
    begin
        repeat (3000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
endmodule
